// file: design/tcr_cfg_if.sv
// Configuration fields passed from the register bank to the timing calculator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface tcr_cfg_if;
	tcr_pkg::tcr_sleep_t sleep_count;
	logic sleep_time_times_eight;
	logic limit_window_times_two;
	logic [1:0] bit_check_count_sel;
	tcr_pkg::tcr_limit_t min_limit;
	tcr_pkg::tcr_range_t rate_range;

	modport src (
		output sleep_count,
		output sleep_time_times_eight,
		output limit_window_times_two,
		output bit_check_count_sel,
		output min_limit,
		output rate_range
	);

	modport dst (
		input sleep_count,
		input sleep_time_times_eight,
		input limit_window_times_two,
		input bit_check_count_sel,
		input min_limit,
		input rate_range
	);
endinterface

// file: design/tcr_ctrl_regs.sv
// Control registers 3 to 5 of the transceiver digital control logic.
// Assumes the serial interface decoder presents one-cycle read and write strobes
// with address and data, all synchronous to i_clk_sys; reset is held while OFF.
`timescale 1ns/1ps
`include "tcr_defines.svh"
// How it works
// - Register 3 bits 7:2 hold frequency word bits 12:7, reset 3840.
// - Register 3 bit 1 switches external supply output, reset on.
// - Supply enable forced to 1 on bit check, key event or power-on flag.
// - Register 3 bit 0 gates the clock output pin, reset on.
// - Clock enable forced to 1 on bit check, key event or power-on flag.
// - Register 4 bit 7 selects amplitude (1) or frequency (0) keying.
// - Register 4 bits 6:2 hold sleep count, reset 10, times 1024 cycles.
// - Register 4 bit 1 multiplies sleep time by 8 when set.
// - Register 4 bit 0 doubles the edge-time limit window when set.
// - Register 5 bits 7:6 choose 0, 3, 6 or 9 checked bits.
// - In receive, bits 5:0 times ext data clock give minimum edge time.
// - In transmit, half bit period is (field + 1) ext data clocks.
// - Ext data clock is 8, 4, 2 or 1 clocks times limit multiplier.
// - Registers are readable and writable and lose contents on reset.
// - Power-on flag set by rising edge on the power-on pin.
module tcr_ctrl_regs #(
	parameter int ADDR_W = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	input wire logic i_bit_check_ok,
	input wire logic i_rx_mode_active,
	input wire logic [4:0] i_key_input_event,
	input wire logic i_power_on_pin,
	input wire logic i_status_read,
	input wire logic [1:0] i_bit_rate_range,
	input wire logic i_tx_mode_active,
	output logic o_power_on_flag,
	output logic [12:0] o_rf_freq_high_word,
	output logic o_ext_supply_output_on,
	output logic o_clock_out_enable,
	output logic o_amplitude_not_frequency_keying,
	output logic [4:0] o_ext_data_clock_period,
	output logic [17:0] o_sleep_cycles,
	output logic [10:0] o_edge_time_cycles,
	output logic [3:0] o_bit_check_bits
);
	// Offsets below three bits cannot reach register 5
	if (ADDR_W < 3) begin : g_addr_w_check
		$error("ADDR_W too small for offsets up to 4");
	end

	localparam logic [7:0] RST_FREQ_HIGH = `TCR_RST_FREQ_HIGH;

	logic [5:0] rf_freq_high_word_q;
	logic [5:0] rf_freq_high_word_d;
	logic ext_supply_output_on_q;
	logic ext_supply_output_on_d;
	logic clock_out_enable_q;
	logic clock_out_enable_d;
	logic [7:0] freq_high_and_output_enables;
	logic [7:0] modulation_sleep_config_q;
	logic [7:0] bit_check_and_min_limit_q;
	logic [7:0] rd_data_d;
	logic power_on_pin_q;
	logic power_on_rise;
	logic power_on_flag_q;
	logic power_on_flag_d;
	logic bit_check_force;
	logic key_force;
	logic force_enables;
	logic wr_freq;
	logic wr_mod;
	logic wr_chk;
	logic [10:0] min_limit_cycles;
	logic [10:0] tx_half_bit_cycles;
	logic [10:0] edge_time_cycles_d;

	tcr_cfg_if cfg ();

	assign wr_freq = i_wr_en && (i_addr == ADDR_W'(`TCR_OFS_FREQ_HIGH));
	assign wr_mod = i_wr_en && (i_addr == ADDR_W'(`TCR_OFS_MOD_SLEEP));
	assign wr_chk = i_wr_en && (i_addr == ADDR_W'(`TCR_OFS_CHK_LIMIT));

	// Previous pin level for the wake edge detector
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			power_on_pin_q <= 1'b0;
		end else begin
			power_on_pin_q <= i_power_on_pin;
		end
	end

	assign power_on_rise = i_power_on_pin && !power_on_pin_q;

	// Sticky wake flag; a new edge beats a clearing status read
	always_comb begin
		power_on_flag_d = power_on_flag_q;
		if (power_on_rise) begin
			power_on_flag_d = 1'b1;
		end else if (i_status_read) begin
			power_on_flag_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			power_on_flag_q <= 1'b0;
		end else begin
			power_on_flag_q <= power_on_flag_d;
		end
	end

	// Bit check counts only in receive or receive-polling mode
	assign bit_check_force = i_bit_check_ok && i_rx_mode_active;
	assign key_force = |i_key_input_event;
	assign force_enables = bit_check_force || key_force || power_on_flag_q;

	// Register 3 frequency field
	always_comb begin
		rf_freq_high_word_d = rf_freq_high_word_q;
		if (wr_freq) begin
			rf_freq_high_word_d = i_wr_data[`TCR_FREQ_MSB:`TCR_FREQ_LSB];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rf_freq_high_word_q <= RST_FREQ_HIGH[`TCR_FREQ_MSB:`TCR_FREQ_LSB];
		end else begin
			rf_freq_high_word_q <= rf_freq_high_word_d;
		end
	end

	// Register 3 enables; forcing is applied last so it beats a write of 0
	always_comb begin
		ext_supply_output_on_d = ext_supply_output_on_q;
		if (wr_freq) begin
			ext_supply_output_on_d = i_wr_data[`TCR_SUPPLY_BIT];
		end
		if (force_enables) begin
			ext_supply_output_on_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ext_supply_output_on_q <= RST_FREQ_HIGH[`TCR_SUPPLY_BIT];
		end else begin
			ext_supply_output_on_q <= ext_supply_output_on_d;
		end
	end

	always_comb begin
		clock_out_enable_d = clock_out_enable_q;
		if (wr_freq) begin
			clock_out_enable_d = i_wr_data[`TCR_CLKOUT_BIT];
		end
		if (force_enables) begin
			clock_out_enable_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			clock_out_enable_q <= RST_FREQ_HIGH[`TCR_CLKOUT_BIT];
		end else begin
			clock_out_enable_q <= clock_out_enable_d;
		end
	end

	// Register 4: keying, sleep count and multipliers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			modulation_sleep_config_q <= `TCR_RST_MOD_SLEEP;
		end else if (wr_mod) begin
			modulation_sleep_config_q <= i_wr_data;
		end
	end

	// Register 5: bit-check count and minimum limit; values below 10 left to software
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			bit_check_and_min_limit_q <= `TCR_RST_CHK_LIMIT;
		end else if (wr_chk) begin
			bit_check_and_min_limit_q <= i_wr_data;
		end
	end

	// Read multiplexer, unmapped offsets read zero
	always_comb begin
		case (i_addr)
			ADDR_W'(`TCR_OFS_FREQ_HIGH): rd_data_d = freq_high_and_output_enables;
			ADDR_W'(`TCR_OFS_MOD_SLEEP): rd_data_d = modulation_sleep_config_q;
			ADDR_W'(`TCR_OFS_CHK_LIMIT): rd_data_d = bit_check_and_min_limit_q;
			default: rd_data_d = 8'h00;
		endcase
	end

	// Read data holds until the next read
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_en) begin
			o_rd_data <= rd_data_d;
		end
	end

	assign cfg.sleep_count = modulation_sleep_config_q[`TCR_SLEEP_MSB:`TCR_SLEEP_LSB];
	assign cfg.sleep_time_times_eight = modulation_sleep_config_q[`TCR_SLEEP_TIME_TIMES_EIGHT_BIT];
	assign cfg.limit_window_times_two = modulation_sleep_config_q[`TCR_LIMIT_WINDOW_TIMES_TWO_BIT];
	assign cfg.bit_check_count_sel = bit_check_and_min_limit_q[`TCR_CHK_MSB:`TCR_CHK_LSB];
	assign cfg.min_limit = bit_check_and_min_limit_q[`TCR_LIM_MSB:`TCR_LIM_LSB];
	assign cfg.rate_range = tcr_pkg::tcr_range_t'(i_bit_rate_range);

	tcr_timing_calc u_calc (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.cfg(cfg),
		.o_ext_data_clock_period(o_ext_data_clock_period),
		.o_sleep_cycles(o_sleep_cycles),
		.o_min_limit_cycles(min_limit_cycles),
		.o_tx_half_bit_cycles(tx_half_bit_cycles),
		.o_bit_check_bits(o_bit_check_bits)
	);

	// Same field serves as receive limit or transmit half bit
	assign edge_time_cycles_d = i_tx_mode_active ? tx_half_bit_cycles : min_limit_cycles;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_edge_time_cycles <= 11'h020;
		end else begin
			o_edge_time_cycles <= edge_time_cycles_d;
		end
	end

	assign freq_high_and_output_enables = {rf_freq_high_word_q, ext_supply_output_on_q,
		clock_out_enable_q};
	assign o_rf_freq_high_word = {rf_freq_high_word_q, 7'h00};
	assign o_ext_supply_output_on = ext_supply_output_on_q;
	assign o_clock_out_enable = clock_out_enable_q;
	assign o_amplitude_not_frequency_keying = modulation_sleep_config_q[`TCR_KEYING_BIT];
	assign o_power_on_flag = power_on_flag_q;
endmodule

// file: design/tcr_defines.svh
// Offsets, field positions, reset values and figures of the control registers 3 to 5.
// Assumes inclusion by bare name from design files only.
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// Register offsets on the serial register port
`define TCR_OFS_FREQ_HIGH 4'h2
`define TCR_OFS_MOD_SLEEP 4'h3
`define TCR_OFS_CHK_LIMIT 4'h4

// Register 3 fields
`define TCR_FREQ_MSB 7
`define TCR_FREQ_LSB 2
`define TCR_SUPPLY_BIT 1
`define TCR_CLKOUT_BIT 0
`define TCR_FREQ_SHIFT 7

// Register 4 fields
`define TCR_KEYING_BIT 7
`define TCR_SLEEP_MSB 6
`define TCR_SLEEP_LSB 2
`define TCR_SLEEP_TIME_TIMES_EIGHT_BIT 1
`define TCR_LIMIT_WINDOW_TIMES_TWO_BIT 0

// Register 5 fields
`define TCR_CHK_MSB 7
`define TCR_CHK_LSB 6
`define TCR_LIM_MSB 5
`define TCR_LIM_LSB 0

// Reset values: word 3840, supply on, clock on / FSK, sleep 10, x1, x1 / 3 bits, limit 16
`define TCR_RST_FREQ_HIGH 8'h7b
`define TCR_RST_MOD_SLEEP 8'h28
`define TCR_RST_CHK_LIMIT 8'h50

// Multipliers and sleep base count
`define TCR_SLEEP_BASE 18'h00400
`define TCR_SLEEP_TIME_TIMES_EIGHT_MULT 4'h8
`define TCR_LIMIT_WINDOW_TIMES_TWO_MULT 4'h2
`define TCR_BIT_CHECK_COUNT_SEL_STEP 4'h3

`endif

// file: design/tcr_pkg.sv
// Types shared by the control register bank and its timing calculator.
// Assumes nothing beyond a SystemVerilog compiler.
package tcr_pkg;

	// Bit-rate range selection, held elsewhere in the device
	typedef enum logic [1:0] {
		TCR_RANGE_B0 = 2'h0,
		TCR_RANGE_B1 = 2'h1,
		TCR_RANGE_B2 = 2'h2,
		TCR_RANGE_B3 = 2'h3
	} tcr_range_t;

	typedef logic [5:0] tcr_limit_t;
	typedef logic [4:0] tcr_sleep_t;

endpackage

// file: design/tcr_timing_calc.sv
// Turns the configuration fields into counts of digital clock periods and of checked bits.
// Assumes the fields change only by register writes; outputs are registered.
`timescale 1ns/1ps
`include "tcr_defines.svh"
module tcr_timing_calc (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	tcr_cfg_if.dst cfg,
	output logic [4:0] o_ext_data_clock_period,
	output logic [17:0] o_sleep_cycles,
	output logic [10:0] o_min_limit_cycles,
	output logic [10:0] o_tx_half_bit_cycles,
	output logic [3:0] o_bit_check_bits
);
	logic [4:0] base_d;
	logic [4:0] xdclk_d;

	// Range 0 with the doubled window reaches 16, hence five bits
	always_comb begin
		case (cfg.rate_range)
			tcr_pkg::TCR_RANGE_B0: base_d = 5'h08;
			tcr_pkg::TCR_RANGE_B1: base_d = 5'h04;
			tcr_pkg::TCR_RANGE_B2: base_d = 5'h02;
			default: base_d = 5'h01;
		endcase
		xdclk_d = cfg.limit_window_times_two ? 5'((base_d * `TCR_LIMIT_WINDOW_TIMES_TWO_MULT)) : base_d;
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ext_data_clock_period <= 5'h02;
			o_sleep_cycles <= 18'h02800;
			o_min_limit_cycles <= 11'h020;
			o_tx_half_bit_cycles <= 11'h022;
			o_bit_check_bits <= 4'h3;
		end else begin
			o_ext_data_clock_period <= xdclk_d;
			// Sleep = count x 1024 x multiplier
			o_sleep_cycles <= 18'(18'(cfg.sleep_count) * `TCR_SLEEP_BASE
				* (cfg.sleep_time_times_eight ? 18'(`TCR_SLEEP_TIME_TIMES_EIGHT_MULT) : 18'h1));
			o_min_limit_cycles <= 11'(cfg.min_limit * xdclk_d);
			// Half bit of the transmit rate: (field + 1) x ext data clock, up to 1024
			o_tx_half_bit_cycles <= 11'((7'(cfg.min_limit) + 7'h1) * xdclk_d);
			o_bit_check_bits <= 4'(cfg.bit_check_count_sel * `TCR_BIT_CHECK_COUNT_SEL_STEP);
		end
	end
endmodule

// file: test/tb_top.sv
// Testbench for the control register bank.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rstn = 0, ok = 0, rx = 0, pin = 0, srd = 0, tx = 0, pend = 0;
	logic [4:0] key = 0, p;
	logic [1:0] rng = 2'h2;
	logic wr, rd, flag, sup, cko, ask;
	logic [3:0] ad, bcb;
	logic [4:0] xd;
	logic [7:0] wd, rdat;
	logic [12:0] frq;
	logic [17:0] slp;
	logic [10:0] edt;
	logic [31:0] v, seed = 32'h2d04;
	logic [7:0] exq[$];
	int n_fail = 0, checks_done = 0;
	initial forever #4 clk = ~clk;
	tcr_mcu_model i_tcr_mcu_model(.i_clk_sys(clk), .o_wr_en(wr), .o_rd_en(rd), .o_addr(ad),
		.o_wr_data(wd));
	tcr_ctrl_regs i_tcr_ctrl_regs(.i_clk_sys(clk), .i_resetn(rstn), .i_wr_en(wr), .i_rd_en(rd),
		.i_addr(ad), .i_wr_data(wd), .o_rd_data(rdat), .i_bit_check_ok(ok), .i_rx_mode_active(rx),
		.i_key_input_event(key), .i_power_on_pin(pin), .i_status_read(srd), .i_bit_rate_range(rng),
		.i_tx_mode_active(tx), .o_power_on_flag(flag), .o_rf_freq_high_word(frq),
		.o_ext_supply_output_on(sup), .o_clock_out_enable(cko),
		.o_amplitude_not_frequency_keying(ask), .o_ext_data_clock_period(xd),
		.o_sleep_cycles(slp), .o_edge_time_cycles(edt), .o_bit_check_bits(bcb));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrt(input logic [3:0] a, input logic [7:0] d);
		i_tcr_mcu_model.xfer(1'b1, a, d);
	endtask
	task automatic rdx(input logic [3:0] a, input logic [7:0] e);
		exq.push_back(e);
		i_tcr_mcu_model.xfer(1'b0, a, e);
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Read data lands one edge after the strobe; compared mid-cycle where it is settled
	always @(posedge clk) begin
		pend <= rd;
	end
	always @(negedge clk) begin
		if (pend) begin
			check(rdat, exq.pop_front());
		end
	end
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rstn = 1;
		wrt(4'h5, 8'h00);
		rdx(4'h2, 8'h7b);
		rdx(4'h3, 8'h28);
		rdx(4'h4, 8'h50);
		rdx(4'h7, 8'h00);
		check(frq, 13'd3840);
		check(slp, 18'd10240);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			v = rnd();
			v[5:0] = 6'd10 + 6'(v[13:8] % 54);
			rng = v[17:16];
			tx = v[18];
			i_tcr_mcu_model.gap = i % 3;
			wrt(4'h3, v[31:24]);
			wrt(4'h4, v[7:0]);
			rdx(4'h3, v[31:24]);
			rdx(4'h4, v[7:0]);
			p = 5'((5'h8 >> v[17:16]) << v[24]);
			check(xd, p);
			check(slp, v[30:26] * 18'd1024 * (v[25] ? 8 : 1));
			check(bcb, v[7:6] * 3);
			check(edt, (v[5:0] + tx) * p);
			check(ask, v[31]);
		end
		$display("test config done");
		wrt(4'h2, {v[7:2], 2'b00});
		rdx(4'h2, {v[7:2], 2'b00});
		check(frq, {v[7:2], 7'h00});
		ok = 1;
		@(posedge clk);
		#1 ok = 0;
		check({sup, cko}, 2'b00);
		for (int c = 0; c < 3; c++) begin
			wrt(4'h2, 8'h00);
			rx = 1;
			ok = (c == 0);
			key = (c == 1) ? 5'(5'h1 << (v % 5)) : 5'h0;
			pin = (c == 2);
			repeat (c == 2 ? 2 : 1) @(posedge clk);
			#1 ok = 0;
			key = 0;
			check({sup, cko}, 2'b11);
		end
		check(flag, 1'b1);
		wrt(4'h2, 8'h00);
		check({sup, cko}, 2'b11);
		srd = 1;
		@(posedge clk);
		#1 srd = 0;
		check(flag, 1'b0);
		wrt(4'h2, 8'h00);
		check({sup, cko}, 2'b00);
		$display("test forcing done");
		pin = 0;
		rstn = 0;
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		rdx(4'h2, 8'h7b);
		rdx(4'h4, 8'h50);
		check({sup, cko}, 2'b11);
		check(flag, 1'b0);
		$display("test reset again done");
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule

// file: test/tcr_ctrl_regs_assertions.sv
// Checker for control registers 3 to 5, bound to tcr_ctrl_regs.
// Assumes one clock domain and the design's port names.
`timescale 1ns/1ps
module tcr_ctrl_regs_assertions #(
	parameter int ADDR_W = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic [7:0] o_rd_data,
	input wire logic i_bit_check_ok,
	input wire logic i_rx_mode_active,
	input wire logic [4:0] i_key_input_event,
	input wire logic i_power_on_pin,
	input wire logic o_power_on_flag,
	input wire logic [12:0] o_rf_freq_high_word,
	input wire logic o_ext_supply_output_on,
	input wire logic o_clock_out_enable,
	input wire logic o_amplitude_not_frequency_keying,
	input wire logic [17:0] o_sleep_cycles,
	input wire logic [3:0] o_bit_check_bits
);
	logic pin_q;
	logic frc;
	logic nf;
	logic w2;
	logic w3;
	logic w4;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) pin_q <= 1'b0;
		else pin_q <= i_power_on_pin;
	end
	assign frc = (i_bit_check_ok & i_rx_mode_active) | (|i_key_input_event) | o_power_on_flag;
	// No forcing, not even from a fresh pin edge
	assign nf = !frc && !(i_power_on_pin && !pin_q);
	assign w2 = i_wr_en && i_addr == ADDR_W'(2);
	assign w3 = i_wr_en && i_addr == ADDR_W'(3);
	assign w4 = i_wr_en && i_addr == ADDR_W'(4);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	property p_frq; w2 |=> o_rf_freq_high_word == {$past(i_wr_data[7:2]), 7'h00}; endproperty
	a_frq: assert property (p_frq) else $error("freq word wrong");
	property p_sup; w2 && nf |=> o_ext_supply_output_on == $past(i_wr_data[1]); endproperty
	a_sup: assert property (p_sup) else $error("supply bit wrong");
	property p_clk; w2 && nf |=> o_clock_out_enable == $past(i_wr_data[0]); endproperty
	a_clk: assert property (p_clk) else $error("clock bit wrong");
	property p_frc; frc |=> o_ext_supply_output_on && o_clock_out_enable; endproperty
	a_frc: assert property (p_frc) else $error("enables not forced");
	property p_ask; w3 |=> o_amplitude_not_frequency_keying == $past(i_wr_data[7]); endproperty
	a_ask: assert property (p_ask) else $error("keying wrong");
	property p_slp; w3 |=> ##1 o_sleep_cycles == 18'($past(i_wr_data[6:2], 2)) * 18'h00400
		* ($past(i_wr_data[1], 2) ? 18'h8 : 18'h1); endproperty
	a_slp: assert property (p_slp) else $error("sleep wrong");
	property p_bck; w4 |=> ##1 o_bit_check_bits == 4'($past(i_wr_data[7:6], 2)) * 4'h3; endproperty
	a_bck: assert property (p_bck) else $error("bit check wrong");
	property p_flg; i_power_on_pin && !pin_q |=> o_power_on_flag; endproperty
	a_flg: assert property (p_flg) else $error("flag not set");
	property p_unm; i_rd_en && !(i_addr inside {2, 3, 4}) |=> o_rd_data == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	c_wr3: cover property (w2 && nf);
	c_frc: cover property (frc && w2);
	c_unm: cover property (i_rd_en && i_addr == ADDR_W'(7));
endmodule
bind tcr_ctrl_regs tcr_ctrl_regs_assertions #(.ADDR_W(ADDR_W)) i_tcr_ctrl_regs_assertions (
	.i_clk_sys, .i_resetn, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .i_bit_check_ok,
	.i_rx_mode_active, .i_key_input_event, .i_power_on_pin, .o_power_on_flag, .o_rf_freq_high_word,
	.o_ext_supply_output_on, .o_clock_out_enable, .o_amplitude_not_frequency_keying,
	.o_sleep_cycles, .o_bit_check_bits);

// file: test/tcr_mcu_model.sv
// Controller model: single-byte register strobes behind the serial decoder.
// Assumes the bench calls xfer at 1 ns after a rising edge.
`timescale 1ns/1ps
module tcr_mcu_model (
	input wire logic i_clk_sys,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [3:0] o_addr,
	output logic [7:0] o_wr_data
);
	int gap = 0;
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 4'hf;
		o_wr_data = 8'h00;
	end
	// Bench never enters aux mode, so clearing the supply is legal here
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
		repeat (gap + 1) @(posedge i_clk_sys);
		#1 o_wr_en = w;
		o_rd_en = !w;
		o_addr = a;
		o_wr_data = d;
		@(posedge i_clk_sys);
		#1 o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = ~a;
		o_wr_data = ~d;
	endtask
endmodule
